// ==== rtl/aem_addr_match.sv ====
// aem_addr_match: one ipv4 address filter with don't-care, host and network modes.
// assumes: purely combinational use inside the entry matcher.
`timescale 1ns/100ps
`default_nettype none
module aem_addr_match (
  // configuration
  input  wire logic [1:0]  mode_i,
  input  wire logic [31:0] ref_i,
  input  wire logic [31:0] mask_i,
  // frame field
  input  wire logic [31:0] addr_i,
  // verdict
  output logic             ok_o
);

  // an unused mode code never matches, so a bad write cannot open the entry
  always_comb begin
    case (mode_i)
      aem_pkg::ADDR_ANY:  ok_o = 1'b1;
      aem_pkg::ADDR_HOST: ok_o = (addr_i == ref_i);
      aem_pkg::ADDR_NET:  ok_o = ((addr_i & mask_i) == (ref_i & mask_i));
      default:            ok_o = 1'b0;
    endcase
  end

endmodule : aem_addr_match
`default_nettype wire

// ==== rtl/aem_entry_matcher.sv ====
// aem_entry_matcher: one access entry of the ingress classifier with its
// configuration registers on avalon-mm.
// assumes: the parser presents one frame per valid cycle, synchronous to clk_i;
// the verdict follows one cycle later.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - protocol filter: any, specific number, icmp, udp or tcp
// - specific protocol 0 to 255 matches only equal ipv4 protocol field
// - icmp, udp, tcp select that protocol and require extra field checks
// - ttl zero setting rejects ttl above zero; nonzero setting needs it above
// - fragment no rejects fragmented frames; yes accepts only fragmented ones
// - options no rejects frames with options; yes accepts only those with
// - ttl, fragment and options each have a don't-care setting
// - source address filter: any, host exact, network under mask
// - arp opcode filter: any, arp, rarp, or neither of them
// - request/reply filter: any, request opcodes, reply opcodes
// - arp sender address filter: any, host exact, network under mask
// - arp target address filter with the same three settings
// - matching frame is discarded under deny, passed under permit
module aem_entry_matcher (
  // clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // avalon-mm slave
  input  wire logic [7:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // frame from the parser
  input  wire aem_pkg::aem_frame_s frame_i,
  // verdict to forwarding
  output aem_pkg::aem_result_s     result_o
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  aem_pkg::aem_bus_e bus_state;
  logic [31:0] ctrl;
  logic [31:0] ip_cfg;
  logic [31:0] arp_cfg;
  logic [31:0] addr_ref  [aem_pkg::N_ADDR];
  logic [31:0] addr_mask [aem_pkg::N_ADDR];
  logic [31:0] hits;
  logic [31:0] next_readdata;
  logic [7:0]  pair_off;
  logic        in_pairs;
  logic [1:0]  pair_idx;
  logic        pair_is_mask;
  logic        wr_fire;
  logic [31:0] frame_addr [aem_pkg::N_ADDR];
  logic [1:0]  addr_mode  [aem_pkg::N_ADDR];
  logic [aem_pkg::N_ADDR-1:0] addr_ok;
  logic        proto_ok;
  logic        ttl_ok;
  logic        frag_ok;
  logic        opt_ok;
  logic        op_ok;
  logic        rr_ok;
  logic        fragmented;
  logic        ip_ok;
  logic        arp_ok;
  logic        type_ok;
  logic        next_match;

  // byte-lane merge of a write into a register, reserved bits kept at zero
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] keep);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r & keep;
  endfunction : merge

  // reset release through two flops; frozen with everything else while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'b00;
    end else if (ce_i) begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // address-pair decode for the eight filter address/mask registers
  assign pair_off     = avs_address_i - aem_pkg::OFF_ADDR_LO;
  assign in_pairs     = (avs_address_i >= aem_pkg::OFF_ADDR_LO) && (avs_address_i <= aem_pkg::OFF_ADDR_HI);
  assign pair_idx     = pair_off[4:3];
  assign pair_is_mask = pair_off[2];

  // bus handshake: waitrequest drops for exactly one cycle per access, so every
  // access completes in two cycles; back-to-back requests are not overlapped
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_state         <= aem_pkg::AEM_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      case (bus_state)
        aem_pkg::AEM_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state         <= aem_pkg::AEM_BUS_ACK;
            avs_waitrequest_o <= 1'b0;
          end
        end
        aem_pkg::AEM_BUS_ACK: begin
          bus_state         <= aem_pkg::AEM_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state         <= aem_pkg::AEM_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // a write lands at the edge where the master sees waitrequest low
  assign wr_fire = avs_write_i && (bus_state == aem_pkg::AEM_BUS_ACK);

  // read mux; unmapped offsets read as zero
  always_comb begin
    next_readdata = aem_pkg::RESET_WORD;
    if (avs_address_i == aem_pkg::OFF_CTRL) begin
      next_readdata = ctrl;
    end else if (avs_address_i == aem_pkg::OFF_IP_CFG) begin
      next_readdata = ip_cfg;
    end else if (avs_address_i == aem_pkg::OFF_ARP_CFG) begin
      next_readdata = arp_cfg;
    end else if (avs_address_i == aem_pkg::OFF_STATUS) begin
      next_readdata[aem_pkg::ST_MATCH]   = result_o.match;
      next_readdata[aem_pkg::ST_DISCARD] = result_o.discard;
    end else if (in_pairs && !avs_address_i[1] && !avs_address_i[0]) begin
      next_readdata = pair_is_mask ? addr_mask[pair_idx] : addr_ref[pair_idx];
    end else if (avs_address_i == aem_pkg::OFF_HITS) begin
      next_readdata = hits;
    end
  end

  // read data is loaded as waitrequest drops and stands through the ack cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= aem_pkg::RESET_WORD;
    end else if (ce_i) begin
      if (avs_read_i && (bus_state == aem_pkg::AEM_BUS_IDLE)) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // control and filter configuration registers; writes to unmapped offsets vanish
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= aem_pkg::RESET_WORD;
      ip_cfg  <= aem_pkg::RESET_WORD;
      arp_cfg <= aem_pkg::RESET_WORD;
    end else if (ce_i && wr_fire) begin
      if (avs_address_i == aem_pkg::OFF_CTRL) begin
        ctrl <= merge(ctrl, avs_writedata_i, avs_byteenable_i, aem_pkg::CTRL_MASK);
      end else if (avs_address_i == aem_pkg::OFF_IP_CFG) begin
        ip_cfg <= merge(ip_cfg, avs_writedata_i, avs_byteenable_i, aem_pkg::IP_CFG_MASK);
      end else if (avs_address_i == aem_pkg::OFF_ARP_CFG) begin
        arp_cfg <= merge(arp_cfg, avs_writedata_i, avs_byteenable_i, aem_pkg::ARP_CFG_MASK);
      end
    end
  end

  // address/mask pairs and their filters, one per address field
  assign frame_addr[aem_pkg::AM_SRC] = frame_i.src_ip;
  assign frame_addr[aem_pkg::AM_DST] = frame_i.dst_ip;
  assign frame_addr[aem_pkg::AM_SND] = frame_i.snd_ip;
  assign frame_addr[aem_pkg::AM_TGT] = frame_i.tgt_ip;
  assign addr_mode[aem_pkg::AM_SRC]  = ip_cfg[aem_pkg::IP_SRC_MODE +: 2];
  assign addr_mode[aem_pkg::AM_DST]  = ip_cfg[aem_pkg::IP_DST_MODE +: 2];
  assign addr_mode[aem_pkg::AM_SND]  = arp_cfg[aem_pkg::ARP_SND_MODE +: 2];
  assign addr_mode[aem_pkg::AM_TGT]  = arp_cfg[aem_pkg::ARP_TGT_MODE +: 2];

  for (genvar i = 0; i < aem_pkg::N_ADDR; i++) begin : g_addr
    // stored address and mask of filter i
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        addr_ref[i]  <= aem_pkg::RESET_WORD;
        addr_mask[i] <= aem_pkg::RESET_WORD;
      end else if (ce_i && wr_fire && in_pairs && (pair_idx == 2'(i))) begin
        if (pair_is_mask) begin
          addr_mask[i] <= merge(addr_mask[i], avs_writedata_i, avs_byteenable_i, '1);
        end else begin
          addr_ref[i] <= merge(addr_ref[i], avs_writedata_i, avs_byteenable_i, '1);
        end
      end
    end

    aem_addr_match u_match (
      .mode_i (addr_mode[i]),
      .ref_i  (addr_ref[i]),
      .mask_i (addr_mask[i]),
      .addr_i (frame_addr[i]),
      .ok_o   (addr_ok[i])
    );
  end

  // protocol filter; the extra icmp/udp/tcp field verdict arrives as l4_ok
  always_comb begin
    case (ip_cfg[aem_pkg::IP_PROTO_MODE +: 3])
      aem_pkg::PROTO_ANY:  proto_ok = 1'b1;
      aem_pkg::PROTO_SPEC: proto_ok = (frame_i.proto == ip_cfg[aem_pkg::IP_PROTO_VAL +: 8]);
      aem_pkg::PROTO_ICMP: proto_ok = (frame_i.proto == aem_pkg::IPP_ICMP) && frame_i.l4_ok;
      aem_pkg::PROTO_UDP:  proto_ok = (frame_i.proto == aem_pkg::IPP_UDP) && frame_i.l4_ok;
      aem_pkg::PROTO_TCP:  proto_ok = (frame_i.proto == aem_pkg::IPP_TCP) && frame_i.l4_ok;
      default:             proto_ok = 1'b0;
    endcase
  end

  // ttl, fragment and options flags; FLAG_NO means zero / absent
  assign fragmented = frame_i.more_frag || (frame_i.frag_off != '0);

  always_comb begin
    case (ip_cfg[aem_pkg::IP_TTL_MODE +: 2])
      aem_pkg::FLAG_ANY: ttl_ok = 1'b1;
      aem_pkg::FLAG_NO:  ttl_ok = (frame_i.ttl == '0);
      aem_pkg::FLAG_YES: ttl_ok = (frame_i.ttl != '0);
      default:           ttl_ok = 1'b0;
    endcase
    case (ip_cfg[aem_pkg::IP_FRAG_MODE +: 2])
      aem_pkg::FLAG_ANY: frag_ok = 1'b1;
      aem_pkg::FLAG_NO:  frag_ok = !fragmented;
      aem_pkg::FLAG_YES: frag_ok = fragmented;
      default:           frag_ok = 1'b0;
    endcase
    case (ip_cfg[aem_pkg::IP_OPT_MODE +: 2])
      aem_pkg::FLAG_ANY: opt_ok = 1'b1;
      aem_pkg::FLAG_NO:  opt_ok = !frame_i.options;
      aem_pkg::FLAG_YES: opt_ok = frame_i.options;
      default:           opt_ok = 1'b0;
    endcase
  end

  // arp opcode and request/reply filters
  always_comb begin
    case (arp_cfg[aem_pkg::ARP_OP_MODE +: 2])
      aem_pkg::OP_ANY:   op_ok = 1'b1;
      aem_pkg::OP_ARP:   op_ok = (frame_i.arp_op == aem_pkg::OPC_ARP_REQ) ||
                                 (frame_i.arp_op == aem_pkg::OPC_ARP_REPLY);
      aem_pkg::OP_RARP:  op_ok = (frame_i.arp_op == aem_pkg::OPC_RARP_REQ) ||
                                 (frame_i.arp_op == aem_pkg::OPC_RARP_REPLY);
      default:           op_ok = (frame_i.arp_op < aem_pkg::OPC_ARP_REQ) ||
                                 (frame_i.arp_op > aem_pkg::OPC_RARP_REPLY);
    endcase
    case (arp_cfg[aem_pkg::ARP_RR_MODE +: 2])
      aem_pkg::RR_ANY:   rr_ok = 1'b1;
      aem_pkg::RR_REQ:   rr_ok = (frame_i.arp_op == aem_pkg::OPC_ARP_REQ) ||
                                 (frame_i.arp_op == aem_pkg::OPC_RARP_REQ);
      aem_pkg::RR_REPLY: rr_ok = (frame_i.arp_op == aem_pkg::OPC_ARP_REPLY) ||
                                 (frame_i.arp_op == aem_pkg::OPC_RARP_REPLY);
      default:           rr_ok = 1'b0;
    endcase
  end

  // all filters of the selected frame type must hold; don't-care filters read as true
  assign ip_ok  = proto_ok && ttl_ok && frag_ok && opt_ok &&
                  addr_ok[aem_pkg::AM_SRC] && addr_ok[aem_pkg::AM_DST];
  assign arp_ok = op_ok && rr_ok && addr_ok[aem_pkg::AM_SND] && addr_ok[aem_pkg::AM_TGT];

  // the ip group only looks at ipv4 frames, the arp group only at arp frames
  always_comb begin
    case (ctrl[aem_pkg::CTRL_FTYPE +: 2])
      aem_pkg::FTYPE_ANY:  type_ok = 1'b1;
      aem_pkg::FTYPE_IPV4: type_ok = frame_i.is_ipv4 && ip_ok;
      aem_pkg::FTYPE_ARP:  type_ok = frame_i.is_arp && arp_ok;
      default:             type_ok = 1'b0;
    endcase
  end

  assign next_match = ctrl[aem_pkg::CTRL_ENABLE] && type_ok;

  // registered verdict, valid one cycle after the frame
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result_o <= '0;
    end else if (ce_i) begin
      result_o.valid <= frame_i.valid;
      if (frame_i.valid) begin
        result_o.match   <= next_match;
        result_o.discard <= next_match && ctrl[aem_pkg::CTRL_DENY];
        result_o.pass    <= !(next_match && ctrl[aem_pkg::CTRL_DENY]);
      end
    end
  end

  // match counter; wraps, read-only, so software takes differences
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hits <= aem_pkg::RESET_WORD;
    end else if (ce_i && frame_i.valid && next_match) begin
      hits <= hits + 32'h00000001;
    end
  end

endmodule : aem_entry_matcher
`default_nettype wire

// ==== rtl/aem_pkg.sv ====
// aem_pkg: register map, field layout, mode codes and carrier structs for the
// access entry matcher.
// assumes: a 32-bit avalon-mm register bus with byte addresses.
package aem_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_IP_CFG   = 8'h04;
  localparam logic [7:0] OFF_ARP_CFG  = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_ADDR_LO  = 8'h10; // four address/mask pairs, 8 bytes each
  localparam logic [7:0] OFF_ADDR_HI  = 8'h2c;
  localparam logic [7:0] OFF_HITS     = 8'h30;

  // writable bit masks, also used to clear reserved bits when a write is merged
  localparam logic [31:0] CTRL_MASK    = 32'h0000000f;
  localparam logic [31:0] IP_CFG_MASK  = 32'h0f3fff07;
  localparam logic [31:0] ARP_CFG_MASK = 32'h000000ff;
  localparam logic [31:0] RESET_WORD   = 32'h00000000;

  // ctrl fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DENY   = 1;
  localparam int CTRL_FTYPE  = 2; // 2 bits
  // ip_cfg fields
  localparam int IP_PROTO_MODE = 0;  // 3 bits
  localparam int IP_PROTO_VAL  = 8;  // 8 bits
  localparam int IP_TTL_MODE   = 16; // 2 bits
  localparam int IP_FRAG_MODE  = 18;
  localparam int IP_OPT_MODE   = 20;
  localparam int IP_SRC_MODE   = 24;
  localparam int IP_DST_MODE   = 26;
  // arp_cfg fields
  localparam int ARP_OP_MODE  = 0;
  localparam int ARP_RR_MODE  = 2;
  localparam int ARP_SND_MODE = 4;
  localparam int ARP_TGT_MODE = 6;
  // status fields
  localparam int ST_MATCH   = 0;
  localparam int ST_DISCARD = 1;

  // frame type of the entry
  localparam logic [1:0] FTYPE_ANY  = 2'h0;
  localparam logic [1:0] FTYPE_IPV4 = 2'h1;
  localparam logic [1:0] FTYPE_ARP  = 2'h2;
  // protocol filter modes
  localparam logic [2:0] PROTO_ANY  = 3'h0;
  localparam logic [2:0] PROTO_SPEC = 3'h1;
  localparam logic [2:0] PROTO_ICMP = 3'h2;
  localparam logic [2:0] PROTO_UDP  = 3'h3;
  localparam logic [2:0] PROTO_TCP  = 3'h4;
  // three-way flag modes: ttl (zero/nonzero), fragment and options (no/yes)
  localparam logic [1:0] FLAG_ANY = 2'h0;
  localparam logic [1:0] FLAG_NO  = 2'h1;
  localparam logic [1:0] FLAG_YES = 2'h2;
  // address filter modes
  localparam logic [1:0] ADDR_ANY  = 2'h0;
  localparam logic [1:0] ADDR_HOST = 2'h1;
  localparam logic [1:0] ADDR_NET  = 2'h2;
  // opcode filter and request/reply modes
  localparam logic [1:0] OP_ANY   = 2'h0;
  localparam logic [1:0] OP_ARP   = 2'h1;
  localparam logic [1:0] OP_RARP  = 2'h2;
  localparam logic [1:0] OP_OTHER = 2'h3;
  localparam logic [1:0] RR_ANY   = 2'h0;
  localparam logic [1:0] RR_REQ   = 2'h1;
  localparam logic [1:0] RR_REPLY = 2'h2;

  // wire values
  localparam logic [7:0]  IPP_ICMP       = 8'h01;
  localparam logic [7:0]  IPP_TCP        = 8'h06;
  localparam logic [7:0]  IPP_UDP        = 8'h11;
  localparam logic [15:0] OPC_ARP_REQ    = 16'h0001;
  localparam logic [15:0] OPC_ARP_REPLY  = 16'h0002;
  localparam logic [15:0] OPC_RARP_REQ   = 16'h0003;
  localparam logic [15:0] OPC_RARP_REPLY = 16'h0004;

  localparam int N_ADDR = 4; // source, destination, sender, target
  localparam int AM_SRC = 0;
  localparam int AM_DST = 1;
  localparam int AM_SND = 2;
  localparam int AM_TGT = 3;

  // parsed header fields of one ingress frame
  typedef struct packed {
    logic        valid;
    logic        is_ipv4;
    logic        is_arp;
    logic [7:0]  proto;
    logic [7:0]  ttl;
    logic        more_frag;
    logic [12:0] frag_off;
    logic        options;
    logic        l4_ok;     // verdict of the icmp/udp/tcp field stage
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [15:0] arp_op;
    logic [31:0] snd_ip;
    logic [31:0] tgt_ip;
  } aem_frame_s;

  // per-frame verdict of the entry
  typedef struct packed {
    logic valid;
    logic match;
    logic discard;
    logic pass;
  } aem_result_s;

  // bus handshake states
  typedef enum logic [1:0] {
    AEM_BUS_IDLE = 2'b01,
    AEM_BUS_ACK  = 2'b10
  } aem_bus_e;

endpackage : aem_pkg

// ==== test/aem_entry_matcher_properties.sv ====
// aem_chk: bus handshake and verdict properties of the entry matcher.
// assumes: bound to aem_entry_matcher; ce_i low freezes every watched output.
`timescale 1ns/100ps
`default_nettype none
module aem_chk (
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  // bus handshake
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic                 avs_waitrequest_o,
  // frame path
  input  wire aem_pkg::aem_frame_s  frame_i,
  input  wire aem_pkg::aem_result_s result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // request taken while idle, then exactly one ack cycle
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_ack_next; s_req |=> s_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus ack missing after request");
  property p_ack_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("bus ack without request");
  // one verdict pulse per frame, one cycle later
  property p_res_next; frame_i.valid && ce_i |=> result_o.valid; endproperty
  a_res_next: assert property (p_res_next) else $error("verdict missing after frame");
  property p_res_only; !frame_i.valid && ce_i |=> !result_o.valid; endproperty
  a_res_only: assert property (p_res_only) else $error("verdict without frame");
  // verdict bits hold between frames so forwarding may sample late
  property p_hold; !result_o.valid |-> $stable({result_o.match, result_o.discard, result_o.pass}); endproperty
  a_hold: assert property (p_hold) else $error("verdict changed between frames");
  property p_deny; result_o.valid && result_o.discard |-> result_o.match; endproperty
  a_deny: assert property (p_deny) else $error("discard without match");
  property p_excl; result_o.valid |-> !(result_o.discard && result_o.pass); endproperty
  a_excl: assert property (p_excl) else $error("discard and pass together");
  property p_pass; result_o.valid && !result_o.match |-> result_o.pass; endproperty
  a_pass: assert property (p_pass) else $error("unmatched frame not passed");
endmodule : aem_chk
bind aem_entry_matcher aem_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .frame_i(frame_i), .result_o(result_o));
`default_nettype wire

// ==== test/aem_parser_model.sv ====
// aem_parser_model: ingress parser stand-in that launches frames and collects verdicts.
// assumes: one frame at a time, verdict one cycle after the frame edge.
`timescale 1ns/100ps
`default_nettype none
module aem_parser_model (
  // clock
  input  wire logic                 clk_i,
  // verdict from the entry
  input  wire aem_pkg::aem_result_s result_i,
  // frame to the entry
  output aem_pkg::aem_frame_s       frame_o
);
  initial frame_o = '0;
  // idle fields carry inverted junk so stale fields cannot pass for live ones
  task automatic send(input aem_pkg::aem_frame_s f, output aem_pkg::aem_result_s r);
    aem_pkg::aem_frame_s j;
    j = ~f;
    j.valid = 1'b0;
    @(posedge clk_i);
    frame_o <= f;
    @(posedge clk_i);
    frame_o <= j;
    @(posedge clk_i);
    r = result_i;
  endtask : send
endmodule : aem_parser_model
`default_nettype wire

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the access entry matcher.
// assumes: bus tasks wait for waitrequest low; parser model owns the frame lines.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                 clk_i = 0, rst_n_i = 0, ce_i = 1;
  logic [3:0]           avs_byteenable_i = 4'hf;
  logic [7:0]           avs_address_i = 0;
  logic                 avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic [31:0]          avs_writedata_i = 0, avs_readdata_o, q;
  aem_pkg::aem_frame_s  frame_i, f;
  aem_pkg::aem_result_s result_o;
  int                   mismatches = 0, n_compared = 0, cycles = 0, hits = 0;
  always #2.5 clk_i = ~clk_i;
  aem_entry_matcher dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .frame_i(frame_i), .result_o(result_o));
  aem_parser_model pm (.clk_i(clk_i), .result_i(result_o), .frame_o(frame_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one avalon access; request held until waitrequest is sampled low, hang guard ends a stuck wait
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(0, a, 0);
    check(q, exp, what);
  endtask : rd
  task automatic cfg(input logic [31:0] c, input logic [31:0] ip, input logic [31:0] arp);
    bus(1, aem_pkg::OFF_CTRL, c);
    bus(1, aem_pkg::OFF_IP_CFG, ip);
    bus(1, aem_pkg::OFF_ARP_CFG, arp);
  endtask : cfg
  function automatic aem_pkg::aem_frame_s mk(input bit ip);
    mk = '0;
    mk.is_ipv4 = ip;
    mk.is_arp = !ip;
    mk.l4_ok = 1'b1;
  endfunction : mk
  // send one frame and compare the whole verdict; hits tracked from expectations
  task automatic fr(input aem_pkg::aem_frame_s x, input logic m, input string what, input logic d = 0);
    aem_pkg::aem_result_s r;
    x.valid = 1'b1;
    pm.send(x, r);
    hits += m;
    check({r.valid, r.match, r.discard, r.pass}, {1'b1, m, d, !d}, what);
  endtask : fr
  task automatic t_regs;
    for (int i = 0; i < 13; i++) rd(8'(4 * i), 0, "reset word");
    bus(1, aem_pkg::OFF_IP_CFG, 32'hffffffff);
    rd(aem_pkg::OFF_IP_CFG, aem_pkg::IP_CFG_MASK, "reserved bits");
    // clear only lane 1: the other lanes must keep their bits
    avs_byteenable_i <= 4'h2;
    bus(1, aem_pkg::OFF_IP_CFG, 0);
    avs_byteenable_i <= 4'hf;
    rd(aem_pkg::OFF_IP_CFG, aem_pkg::IP_CFG_MASK & 32'hffff00ff, "byte lanes");
    rd(8'h34, 0, "unmapped read");
    bus(1, aem_pkg::OFF_HITS, 32'h5);
    rd(aem_pkg::OFF_HITS, 0, "hits read only");
    $display("register test done");
  endtask : t_regs
  task automatic t_proto;
    logic [7:0] p[3] = '{8'h01, 8'h11, 8'h06};
    cfg(5, 32'h0000ff01, 0);
    f = mk(1);
    f.proto = 8'hff;
    fr(f, 1, "proto ff");
    f.proto = 8'hfe;
    fr(f, 0, "proto fe");
    f = mk(0);
    f.proto = 8'hff;
    fr(f, 0, "arp frame");
    for (int m = 2; m < 5; m++) begin
      cfg(5, m, 0);
      f = mk(1);
      f.proto = p[m-2];
      fr(f, 1, "l4 proto");
      f.l4_ok = 0;
      fr(f, 0, "l4 fields");
      f.l4_ok = 1;
      f.proto = p[(m-1)%3];
      fr(f, 0, "other proto");
    end
    cfg(5, 0, 0);
    fr(f, 1, "proto any");
    $display("protocol test done");
  endtask : t_proto
  // per flag: mode any/no/yes against a clear field and two set cases: ttl 1 and ff, more_frag or frag_off, options set twice
  task automatic t_flags;
    for (int k = 0; k < 3; k++) for (int m = 0; m < 3; m++) begin
      cfg(5, 32'(m) << (16 + 2 * k), 0);
      for (int b = 0; b < 3; b++) begin
        f = mk(1);
        case (k)
          0: f.ttl = (b == 2) ? 8'hff : 8'(b);
          1: begin
            f.more_frag = (b == 1);
            f.frag_off = 13'(b == 2);
          end
          default: f.options = (b != 0);
        endcase
        fr(f, m == 0 || ((m == 1) == (b == 0)), "flag mode");
      end
    end
    $display("flag test done");
  endtask : t_flags
  // address filters: exact, low bit off (inside mask hole), bit 8 on (masked)
  task automatic t_addr;
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'(16 + 8 * i), 32'hc0a80a01);
      bus(1, 8'(20 + 8 * i), 32'hffffff00);
      for (int m = 0; m < 3; m++) begin
        if (i < 2) cfg(5, 32'(m) << (24 + 2 * i), 0);
        else cfg(9, 0, 32'(m) << (2 * i));
        for (int d = 0; d < 3; d++) begin
          f = mk(i < 2);
          a = 32'hc0a80a01 ^ (d == 1 ? 32'h1 : d == 2 ? 32'h100 : 32'h0);
          case (i)
            0: f.src_ip = a;
            1: f.dst_ip = a;
            2: f.snd_ip = a;
            default: f.tgt_ip = a;
          endcase
          fr(f, m == 0 || d == 0 || (m == 2 && d == 1), "address");
        end
      end
    end
    $display("address test done");
  endtask : t_addr
  // opcodes 1..4 are arp/rarp request/reply, 5 is neither
  task automatic t_arp;
    for (int m = 0; m < 4; m++) begin
      cfg(9, 0, m);
      for (int j = 0; j < 5; j++) begin
        f = mk(0);
        f.arp_op = 16'(j + 1);
        fr(f, m == 0 || (m == 1 && j < 2) || (m == 2 && (j == 2 || j == 3)) || (m == 3 && j == 4), "opcode");
      end
    end
    for (int m = 0; m < 3; m++) begin
      cfg(9, 0, m << 2);
      for (int j = 0; j < 5; j++) begin
        f = mk(0);
        f.arp_op = 16'(j + 1);
        fr(f, m == 0 || (j < 4 && (m == 1) == (j % 2 == 0)), "request reply");
      end
    end
    $display("opcode test done");
  endtask : t_arp
  task automatic t_action;
    aem_pkg::aem_result_s r;
    f = mk(1);
    f.ttl = 8'hff;
    cfg(7, 0, 0);
    fr(f, 1, "deny", 1);
    rd(aem_pkg::OFF_STATUS, 3, "status deny");
    cfg(7, 32'h00010000, 0);
    fr(f, 0, "all filters");
    cfg(9, 32'h00010000, 0);
    f.is_ipv4 = 0;
    f.is_arp = 1;
    fr(f, 1, "ipv4 check on arp");
    cfg(0, 0, 0);
    fr(f, 0, "disabled");
    // enable low freezes the entry, so a frame leaves no verdict pulse
    ce_i <= 1'b0;
    f.valid = 1'b1;
    pm.send(f, r);
    ce_i <= 1'b1;
    check(r.valid, 0, "frozen verdict");
    rd(aem_pkg::OFF_STATUS, 0, "status clear");
    rd(aem_pkg::OFF_HITS, hits, "hit count");
    $display("action test done");
  endtask : t_action
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // hang guard, well above the under one thousand cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs;
    t_proto;
    t_flags;
    t_addr;
    t_arp;
    t_action;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
